/* design/sbpt_pkg.sv */
// package of the period timer: register map, control layout, reset values
// assumes a 32-bit axi4-lite register bus with 16-bit byte addresses
package sbpt_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  // each printed offset is a word index; the byte address is four times it
  localparam logic [15:0] IDX_COUNT = 16'h0100;
  localparam logic [15:0] IDX_PERIOD = 16'h0102;
  localparam logic [15:0] IDX_CONTROL = 16'h0104;
  localparam logic [15:0] IDX_EVENT = 16'h0106;
  localparam logic [15:0] ADDR_COUNT = IDX_COUNT << 2;
  localparam logic [15:0] ADDR_PERIOD = IDX_PERIOD << 2;
  localparam logic [15:0] ADDR_CONTROL = IDX_CONTROL << 2;
  localparam logic [15:0] ADDR_EVENT = IDX_EVENT << 2;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    PS_DIV1 = 2'b00,
    PS_DIV8 = 2'b01,
    PS_DIV64 = 2'b10,
    PS_DIV256 = 2'b11
  } sbpt_ps_type;

  typedef struct packed {
    logic timer_on;
    logic rsv14;
    logic idle_stop_sel;
    logic [5:0] rsv12_7;
    logic gate_accum_en;
    sbpt_ps_type prescale_sel;
    logic rsv3;
    logic ext_clk_sync_sel;
    logic clk_source_sel;
    logic rsv0;
  } sbpt_ctrl_type;

  localparam logic [15:0] CTL_WMASK = 16'ha076;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam int unsigned EVT_FLAG_BIT = 0;
  localparam int unsigned EVT_EN_BIT = 1;

  // prescaler terminal counts, divisor minus one
  localparam logic [7:0] TERM_DIV1 = 8'h00;
  localparam logic [7:0] TERM_DIV8 = 8'h07;
  localparam logic [7:0] TERM_DIV64 = 8'h3f;
  localparam logic [7:0] TERM_DIV256 = 8'hff;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* design/sbpt_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes pin is asynchronous to clk; outputs are registered
`timescale 1ns/1ns
module sbpt_pin_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic rise_reg;
  logic fall_reg;
  wire agree = (s2_reg == s3_reg);
  wire level_next = agree ? s3_reg : level_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
      rise_reg <= level_next & ~level_reg;
      fall_reg <= ~level_next & level_reg;
    end
  end

  assign level = level_reg;
  assign rise = rise_reg;
  assign fall = fall_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  edge_level_a: assert property (ce && rise |-> level_reg)
    else $error("rise pulse without high level");

endmodule

/* design/sbpt_prescaler.sv */
// selectable 1/8/64/256 prescaler on a tick stream
// assumes tick_in is already gated by the timer's run condition
`timescale 1ns/1ns
module sbpt_prescaler (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tick_in,
  input wire logic clr,
  input sbpt_pkg::sbpt_ps_type sel,
  output logic tick_out
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  function automatic logic [7:0] term_of(input sbpt_pkg::sbpt_ps_type s);
    case (s)
      sbpt_pkg::PS_DIV1: term_of = sbpt_pkg::TERM_DIV1;
      sbpt_pkg::PS_DIV8: term_of = sbpt_pkg::TERM_DIV8;
      sbpt_pkg::PS_DIV64: term_of = sbpt_pkg::TERM_DIV64;
      sbpt_pkg::PS_DIV256: term_of = sbpt_pkg::TERM_DIV256;
      default: term_of = sbpt_pkg::TERM_DIV1;
    endcase
  endfunction

  wire at_term = (cnt_reg >= term_of(sel));
  assign tick_out = tick_in & at_term & ~clr;

  // a clear always wins over a pending tick
  assign cnt_next = clr ? 8'h00 : (tick_in ? (at_term ? 8'h00 : cnt_reg + 8'h01) : cnt_reg);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= 8'h00;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  prescale_clear_a: assert property (ce && clr |=> cnt_reg == 8'h00)
    else $error("prescaler not cleared");
  prescale_out_a: assert property (tick_out |-> tick_in && cnt_reg == term_of(sel))
    else $error("prescaler tick at wrong count");

endmodule

/* design/sbpt_timer.sv */
// 16-bit period timer with axi4-lite register slave
// assumes cpu_idle/cpu_sleep come from clk-domain logic; the gate/clock pin is async
`timescale 1ns/1ns
module sbpt_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic ext_clock_gate_pin,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a[15:2] == b[15:2]);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [15:0] a);
    mapped = hit(a, sbpt_pkg::ADDR_COUNT) | hit(a, sbpt_pkg::ADDR_PERIOD) |
             hit(a, sbpt_pkg::ADDR_CONTROL) | hit(a, sbpt_pkg::ADDR_EVENT);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  sbpt_pkg::sbpt_ctrl_type ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] period_reg;
  logic flag_reg;
  logic flag_next;
  logic en_reg;
  logic rise_d_reg;

  logic aw_hold_reg;
  logic [15:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic ps_tick;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire do_write = ce & aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire wr_count = do_write & hit(aw_addr_reg, sbpt_pkg::ADDR_COUNT);
  wire wr_period = do_write & hit(aw_addr_reg, sbpt_pkg::ADDR_PERIOD);
  wire wr_ctrl = do_write & hit(aw_addr_reg, sbpt_pkg::ADDR_CONTROL);
  wire wr_event = do_write & hit(aw_addr_reg, sbpt_pkg::ADDR_EVENT);
  wire [15:0] wr_merged_ctrl = merge16(ctrl_reg, w_data_reg, w_strb_reg) & sbpt_pkg::CTL_WMASK;
  wire clr_flag = wr_event & w_strb_reg[0] & w_data_reg[sbpt_pkg::EVT_FLAG_BIT];
  wire [1:0] evt_rd = {en_reg, flag_reg};

  assign s_axi_awready = ce & ~aw_hold_reg;
  assign s_axi_wready = ce & ~w_hold_reg;
  assign s_axi_arready = ce & ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  wire [15:0] rd_val = hit(s_axi_araddr, sbpt_pkg::ADDR_COUNT) ? count_reg :
                       hit(s_axi_araddr, sbpt_pkg::ADDR_PERIOD) ? period_reg :
                       hit(s_axi_araddr, sbpt_pkg::ADDR_CONTROL) ? 16'(ctrl_reg) :
                       hit(s_axi_araddr, sbpt_pkg::ADDR_EVENT) ? {14'h0000, evt_rd} :
                       16'h0000;

  // ****************************************************************
  // counting path
  // ****************************************************************
  sbpt_pin_sync sbpt_pin_sync_i (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pin(ext_clock_gate_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // async mode uses the filtered edge straight away; sync mode realigns it
  // one more stage, standing in for the phase-clock resynchronisation
  wire async_mode = ctrl_reg.clk_source_sel & ~ctrl_reg.ext_clk_sync_sel;
  wire ext_edge = ctrl_reg.ext_clk_sync_sel ? rise_d_reg : pin_rise;
  wire gated = ctrl_reg.gate_accum_en & ~ctrl_reg.clk_source_sel;
  wire raw_tick = ctrl_reg.clk_source_sel ? ext_edge : (gated ? pin_level : 1'b1);
  wire idle_hold = cpu_idle & ctrl_reg.idle_stop_sel;
  wire sleep_hold = cpu_sleep & ~async_mode;
  wire run = ctrl_reg.timer_on & ~idle_hold & ~sleep_hold;
  // the prescaler clock stops while off, so clears only reach a timer whose timer_on bit is set
  wire ps_clr = (wr_count | wr_ctrl) & ctrl_reg.timer_on;
  wire at_period = (count_reg == period_reg);
  wire match_evt = ps_tick & at_period;
  wire gate_evt = ctrl_reg.timer_on & gated & pin_fall;

  sbpt_prescaler sbpt_prescaler_i (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .tick_in(run & raw_tick),
    .clr(ps_clr),
    .sel(ctrl_reg.prescale_sel),
    .tick_out(ps_tick)
  );

  // software write has priority over a same-cycle increment
  assign count_next = wr_count ? merge16(count_reg, w_data_reg, w_strb_reg) :
                      ps_tick ? (at_period ? 16'h0000 : count_reg + 16'h0001) :
                      count_reg;
  // a new event beats a software clear in the same cycle
  assign flag_next = (flag_reg & ~clr_flag) | match_evt | gate_evt;
  assign timer_irq = flag_reg & en_reg;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= sbpt_pkg::sbpt_ctrl_type'(sbpt_pkg::CONTROL_RST);
      count_reg <= sbpt_pkg::COUNT_RST;
      period_reg <= sbpt_pkg::PERIOD_RST;
      flag_reg <= 1'b0;
      en_reg <= 1'b0;
      rise_d_reg <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_reg <= sbpt_pkg::sbpt_ctrl_type'(wr_merged_ctrl);
      end
      if (wr_period) begin
        period_reg <= merge16(period_reg, w_data_reg, w_strb_reg);
      end
      if (wr_event && w_strb_reg[0]) begin
        en_reg <= w_data_reg[sbpt_pkg::EVT_EN_BIT];
      end
      count_reg <= count_next;
      flag_reg <= flag_next;
      rise_d_reg <= pin_rise;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= sbpt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? sbpt_pkg::RESP_OKAY : sbpt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= sbpt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= {16'h0000, rd_val};
        rresp_reg <= mapped(s_axi_araddr) ? sbpt_pkg::RESP_OKAY : sbpt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // a count write overrides any step in the same cycle, so such cycles are left out
  sequence quiet_cycle_s;
    ce && !wr_count;
  endsequence

  // one counting step that is not the wrap
  sequence step_s;
    ps_tick && !at_period;
  endsequence

  wrap_to_zero_a: assert property (quiet_cycle_s and match_evt |=> count_reg == 16'h0000)
    else $error("counter did not wrap at period");
  count_step_a: assert property (quiet_cycle_s and step_s |=>
                                 count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");
  async_edge_a: assert property (ce && run && async_mode && pin_rise && !ps_clr &&
                                 ctrl_reg.prescale_sel == sbpt_pkg::PS_DIV1 |-> ps_tick)
    else $error("async edge not counted");
  sync_edge_a: assert property (ce && run && ctrl_reg.clk_source_sel &&
                                ctrl_reg.ext_clk_sync_sel && rise_d_reg && !ps_clr &&
                                ctrl_reg.prescale_sel == sbpt_pkg::PS_DIV1 |-> ps_tick)
    else $error("synchronised edge not counted");
  idle_hold_a: assert property (quiet_cycle_s and idle_hold |=> $stable(count_reg))
    else $error("counter moved in idle");
  async_idle_a: assert property (quiet_cycle_s and (idle_hold && async_mode) |=>
                                 $stable(count_reg))
    else $error("async counter moved in idle");
  gate_low_a: assert property (quiet_cycle_s and (gated && !pin_level) |=>
                               $stable(count_reg))
    else $error("gated counter moved with gate low");
  sleep_hold_a: assert property (quiet_cycle_s and sleep_hold |=> $stable(count_reg))
    else $error("counter moved in sleep");
  ctrl_write_a: assert property (ce && wr_ctrl && !ps_tick |=> $stable(count_reg))
    else $error("control write changed count");
  off_hold_a: assert property (quiet_cycle_s and !ctrl_reg.timer_on |-> !match_evt ##1
                               $stable(count_reg) && !$rose(flag_reg))
    else $error("disabled timer moved or matched");
  // the prescaler clock is halted while off: its count must not move at all
  off_no_clear_a: assert property (ce && !ctrl_reg.timer_on |=>
                                   $stable(sbpt_prescaler_i.cnt_reg))
    else $error("prescaler moved while off");
  match_flag_a: assert property (ce && (match_evt || gate_evt) |=>
                                 flag_reg && timer_irq == en_reg)
    else $error("event did not set flag");
  evt_clear_a: assert property (ce && clr_flag && !match_evt && !gate_evt |=> !flag_reg)
    else $error("flag not cleared by software");
  gate_fall_a: assert property (ce && gated && ctrl_reg.timer_on && pin_fall |=> flag_reg)
    else $error("gate fall did not set flag");
  flag_sticky_a: assert property (ce && flag_reg && !clr_flag |=> flag_reg)
    else $error("flag dropped without clear");
  write_resp_a: assert property (do_write |=> s_axi_bvalid [*1] ##0 !aw_hold_reg)
    else $error("write not answered");

endmodule

/* tb/sbpt_pin_model.sv */
// far-side model of the external clock / gate pin: bursts of equal high and low phases
// assumes the caller raises go for one clock while busy is low
`timescale 1ns/1ns
module sbpt_pin_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic [7:0] hi_len,
  output logic pin = 1'b0,
  output logic busy = 1'b0
);
  // ****************************************************************
  // pulse generator
  // ****************************************************************
  // pin rests low between bursts, so no stray edge reaches the counter
  // phases are whole clocks, wide enough for the pin filter to agree
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'b1;
      for (int i = 0; i < n_pulses; i++) begin
        pin <= 1'b1;
        repeat (hi_len) @(posedge clk);
        pin <= 1'b0;
        repeat (hi_len) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

/* tb/sbpt_timer_tb.sv */
// self-checking bench of the period timer: register rows, then counting scenarios
// assumes the design files and the pin model are compiled before it
`timescale 1ns/1ns
module sbpt_timer_tb;
  // ****************************************************************
  // signals and tables
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
  } sbpt_row_type;
  localparam logic [1:0] OK = sbpt_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = sbpt_pkg::RESP_SLVERR;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, cpu_idle = 1'b0, cpu_sleep = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, timer_irq, pin, busy, go = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata, x, y;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] n_pulses = 8'h00, hi_len = 8'h08;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n;
  int divs [4] = '{1, 8, 64, 256};
  sbpt_row_type rows [5] = '{
    '{sbpt_pkg::ADDR_PERIOD, 32'hdead_1234, 32'h0000_1234, OK, OK},
    '{sbpt_pkg::ADDR_CONTROL, 32'h0000_7fff, {16'h0000, 16'h7fff & sbpt_pkg::CTL_WMASK}, OK, OK},
    '{sbpt_pkg::ADDR_COUNT, 32'h0000_00ab, 32'h0000_00ab, OK, OK},
    '{sbpt_pkg::ADDR_EVENT, 32'h0000_0003, 32'h0000_0002, OK, OK},
    '{16'h0500, 32'h0000_5555, 32'h0000_0000, ERR, ERR}
  };
  logic [15:0] ra [4] = '{sbpt_pkg::ADDR_COUNT, sbpt_pkg::ADDR_PERIOD, sbpt_pkg::ADDR_CONTROL,
    sbpt_pkg::ADDR_EVENT};
  logic [15:0] rv [4] = '{sbpt_pkg::COUNT_RST, sbpt_pkg::PERIOD_RST, sbpt_pkg::CONTROL_RST,
    16'h0000};

  sbpt_timer sbpt_timer_i (.clk(clk), .rstn(rstn), .ce(ce), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .ext_clock_gate_pin(pin), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_irq(timer_irq));
  sbpt_pin_model sbpt_pin_model_i (.clk(clk), .go(go), .n_pulses(n_pulses),
    .hi_len(hi_len), .pin(pin), .busy(busy));

  // ****************************************************************
  // clock, timeout, checks
  // ****************************************************************
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_resp(input string name, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask

  // ****************************************************************
  // bus and pin tasks
  // ****************************************************************
  // readies and answers are sampled at the falling edge, released on the next rising edge
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, b_hit;
    b_hit = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit) begin
      @(negedge clk);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      b_hit = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit, done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      hit = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_write(a, {16'h0000, d}, r);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
  endtask
  task automatic pulse(input logic [7:0] cnt, input logic [7:0] len);
    @(posedge clk);
    n_pulses <= cnt;
    hi_len <= len;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (busy) @(negedge clk);
    repeat (10) @(posedge clk);
  endtask
  task automatic wait_irq(output int t);
    while (timer_irq !== 1'b1) @(negedge clk);
    t = cycles;
  endtask
  // the first irq seen after a control change is thrown away: its phase is unknown
  task automatic wrap_interval(output int d);
    int ta, tb;
    wait_irq(ta);
    wr(sbpt_pkg::ADDR_EVENT, 16'h0003);
    wait_irq(ta);
    wr(sbpt_pkg::ADDR_EVENT, 16'h0003);
    wait_irq(tb);
    d = tb - ta;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      axi_write(rows[i].addr, rows[i].wdata, resp);
      check_resp("bresp", rows[i].bresp, resp);
      axi_read(rows[i].addr, x, resp);
      check_resp("rresp", rows[i].rresp, resp);
      check_word("rdata", rows[i].rdata, x);
    end
    wr(sbpt_pkg::ADDR_PERIOD, 16'h0013);
    wr(sbpt_pkg::ADDR_COUNT, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(sbpt_pkg::ADDR_CONTROL, 16'h8000 | (16'(k) << 4));
      wrap_interval(n);
      check_word("wrap interval", 32'(20 * divs[k]), 32'(n));
    end
    repeat (30) @(negedge clk);
    check_word("flag held", 32'h1, {31'h0, timer_irq});
    wr(sbpt_pkg::ADDR_CONTROL, 16'h0000);
    rd(sbpt_pkg::ADDR_COUNT, x);
    wr(sbpt_pkg::ADDR_CONTROL, 16'h0030);
    wr(sbpt_pkg::ADDR_EVENT, 16'h0003);
    repeat (40) @(posedge clk);
    rd(sbpt_pkg::ADDR_COUNT, y);
    check_word("count kept", x, y);
    check_word("no event off", 32'h0, {31'h0, timer_irq});
    wr(sbpt_pkg::ADDR_PERIOD, 16'hffff);
    cpu_idle <= 1'b1;
    wr(sbpt_pkg::ADDR_CONTROL, 16'ha000);
    rd(sbpt_pkg::ADDR_COUNT, x);
    repeat (20) @(posedge clk);
    rd(sbpt_pkg::ADDR_COUNT, y);
    check_word("idle stop", x, y);
    wr(sbpt_pkg::ADDR_CONTROL, 16'h8000);
    rd(sbpt_pkg::ADDR_COUNT, x);
    repeat (20) @(posedge clk);
    rd(sbpt_pkg::ADDR_COUNT, y);
    check_word("idle run", 32'h1, {31'h0, x != y});
    // three enabled edges lie between the two read samples; the rest are frozen
    rd(sbpt_pkg::ADDR_COUNT, x);
    ce <= 1'b0;
    repeat (50) @(posedge clk);
    ce <= 1'b1;
    rd(sbpt_pkg::ADDR_COUNT, y);
    check_word("ce freeze", 32'h3, y - x);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    wr(sbpt_pkg::ADDR_CONTROL, 16'h8002);
    wr(sbpt_pkg::ADDR_COUNT, 16'h0000);
    pulse(8'h05, 8'h08);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("async sleep", 32'h5, x);
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    wr(sbpt_pkg::ADDR_CONTROL, 16'ha002);
    pulse(8'h03, 8'h08);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("async idle", 32'h5, x);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    wr(sbpt_pkg::ADDR_CONTROL, 16'h8006);
    wr(sbpt_pkg::ADDR_COUNT, 16'h0000);
    pulse(8'h03, 8'h08);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("sync sleep", 32'h0, x);
    cpu_sleep <= 1'b0;
    pulse(8'h04, 8'h08);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("sync count", 32'h4, x);
    wr(sbpt_pkg::ADDR_CONTROL, 16'h8040);
    wr(sbpt_pkg::ADDR_EVENT, 16'h0003);
    wr(sbpt_pkg::ADDR_COUNT, 16'h0000);
    repeat (20) @(posedge clk);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("gate low", 32'h0, x);
    check_word("no gate event", 32'h0, {31'h0, timer_irq});
    pulse(8'h01, 8'h28);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("gate high", 32'h1, {31'h0, x > 32'h20});
    check_word("gate fall", 32'h1, {31'h0, timer_irq});
    // divide by 256: a missed prescaler clear would have ticked once by the read
    wr(sbpt_pkg::ADDR_CONTROL, 16'h8030);
    wr(sbpt_pkg::ADDR_COUNT, 16'h0000);
    repeat (200) @(posedge clk);
    wr(sbpt_pkg::ADDR_COUNT, 16'h0000);
    repeat (200) @(posedge clk);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("count write clear", 32'h0, x);
    wr(sbpt_pkg::ADDR_COUNT, 16'h0000);
    repeat (200) @(posedge clk);
    wr(sbpt_pkg::ADDR_CONTROL, 16'h8030);
    repeat (200) @(posedge clk);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("control write clear", 32'h0, x);
    repeat (100) @(posedge clk);
    rd(sbpt_pkg::ADDR_COUNT, x);
    check_word("div256 tick", 32'h1, x);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], x);
      check_word("reset value", {16'h0000, rv[i]}, x);
    end
    check_word("irq after reset", 32'h0, {31'h0, timer_irq});
    give_verdict;
  end
endmodule
